/* File: core/srbs_regs.svh */
// register indices, field positions, reset values and recovery counts
`ifndef SRBS_REGS_SVH
`define SRBS_REGS_SVH

`define SRBS_ADDR_W 18
`define SRBS_IDX_W 16
`define SRBS_IDX_BREAK_STATUS 16'hFE00
`define SRBS_IDX_RESET_CAUSE 16'hFE01
`define SRBS_IDX_BREAK_CTRL 16'hFE03
`define SRBS_IDX_EVT_STATUS 16'hFE04
`define SRBS_IDX_EVT_CLEAR 16'hFE05
`define SRBS_IDX_EVT_ENABLE 16'hFE06
`define SRBS_IDX_LP_CONFIG 16'hFE07

`define SRBS_BIT_EXIT_FLAG 0
`define SRBS_BIT_POR 0
`define SRBS_BIT_PIN 1
`define SRBS_BIT_WATCHDOG 2
`define SRBS_BIT_BAD_OPCODE 3
`define SRBS_BIT_BAD_FETCH 4
`define SRBS_BIT_LOW_VOLTAGE 5
`define SRBS_BIT_CLEAR_ENABLE 0
`define SRBS_BIT_EVT_BREAK_EXIT 0
`define SRBS_BIT_EVT_RECOVERED 1
`define SRBS_BIT_SHORT_RECOVERY 0
`define SRBS_BIT_LP_STATE_LO 2

`define SRBS_RST_BYTE 8'h00
`define SRBS_RST_EVT 2'h0

`define SRBS_RECOVER_NORMAL 4096
`define SRBS_RECOVER_SHORT 32
`define SRBS_CNT_W 13

`endif

/* File: core/srbs_pkg.sv */
// types shared by the reset and break status block
package srbs_pkg;

  typedef enum logic [1:0] {
    LP_RUN = 2'b00,
    LP_WAIT = 2'b01,
    LP_STOP = 2'b10,
    LP_RECOVER = 2'b11
  } srbs_lp_e;

  typedef struct packed {
    logic por;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_address;
    logic address_was_fetch;
    logic low_voltage;
  } srbs_cause_s;

  typedef struct packed {
    logic recovered;
    logic break_exit;
  } srbs_evt_s;

endpackage

/* File: core/srbs_top.sv */
// reset cause, break exit status, break flag gating and stop recovery timer
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "srbs_regs.svh"

module srbs_top #(
  parameter int NUM_FLAGS = 8,
  parameter int NORMAL_RECOVERY = `SRBS_RECOVER_NORMAL,
  parameter int SHORT_RECOVERY = `SRBS_RECOVER_SHORT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SRBS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_entry,
  input wire logic wait_entry,
  input wire logic wake_interrupt,
  input wire logic break_irq,
  input wire logic break_state,
  input wire logic crystal_clock,
  input wire srbs_pkg::srbs_cause_s reset_cause,
  input wire logic [NUM_FLAGS-1:0] flag_clear_request,
  output logic [NUM_FLAGS-1:0] flag_clear_grant,
  output logic stop_mode,
  output logic recovery_busy,
  output logic recovery_done,
  output logic irq
);
  import srbs_pkg::*;

  localparam logic [`SRBS_CNT_W-1:0] NORMAL_LAST =
    `SRBS_CNT_W'(NORMAL_RECOVERY - 1);
  localparam logic [`SRBS_CNT_W-1:0] SHORT_LAST =
    `SRBS_CNT_W'(SHORT_RECOVERY - 1);

  srbs_lp_e lp_state;
  srbs_cause_s cause_q1;
  srbs_cause_s cause_q2;
  srbs_evt_s evt_status;
  srbs_evt_s evt_enable;
  logic [1:0] cap_cnt;
  logic capture;
  logic [5:0] cause_flags;
  logic exit_flag;
  logic clear_enable;
  logic short_recovery;
  logic xclk_q1;
  logic xclk_q2;
  logic xclk_q3;
  logic xclk_rise;
  logic [`SRBS_CNT_W-1:0] rec_cnt;
  logic [`SRBS_CNT_W-1:0] rec_last;
  logic rec_end;
  logic wake;
  logic set_exit;
  logic [`SRBS_IDX_W-1:0] idx;
  logic hit_bs;
  logic hit_rc;
  logic hit_bc;
  logic hit_es;
  logic hit_ec;
  logic hit_ee;
  logic hit_lp;
  logic mapped;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic clear_allow;
  logic [31:0] next_rdata;

  // register decode; each register is one word at four times its index
  assign idx = paddr[`SRBS_ADDR_W-1:2];
  assign hit_bs = (idx == `SRBS_IDX_BREAK_STATUS);
  assign hit_rc = (idx == `SRBS_IDX_RESET_CAUSE);
  assign hit_bc = (idx == `SRBS_IDX_BREAK_CTRL);
  assign hit_es = (idx == `SRBS_IDX_EVT_STATUS);
  assign hit_ec = (idx == `SRBS_IDX_EVT_CLEAR);
  assign hit_ee = (idx == `SRBS_IDX_EVT_ENABLE);
  assign hit_lp = (idx == `SRBS_IDX_LP_CONFIG);
  assign mapped = hit_bs | hit_rc | hit_bc | hit_es | hit_ec | hit_ee
    | hit_lp;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  // zero wait states, so every access phase completes
  assign pready = 1'b1;
  assign wr = access & pwrite & mapped;
  assign rd = access & ~pwrite & mapped;

  // read data is built in setup and held through the access phase
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit_bs)
    begin
      next_rdata[`SRBS_BIT_EXIT_FLAG] = exit_flag;
    end
    if (hit_rc)
    begin
      next_rdata[5:0] = cause_flags;
    end
    if (hit_bc)
    begin
      next_rdata[`SRBS_BIT_CLEAR_ENABLE] = clear_enable;
    end
    if (hit_es)
    begin
      next_rdata[1:0] = evt_status;
    end
    if (hit_ee)
    begin
      next_rdata[1:0] = evt_enable;
    end
    if (hit_lp)
    begin
      next_rdata[`SRBS_BIT_SHORT_RECOVERY] = short_recovery;
      next_rdata[`SRBS_BIT_LP_STATE_LO+:2] = lp_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= ~mapped;
    end
  end

  // reset cause inputs are levels from the reset logic: synchronise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cause_q1 <= '0;
      cause_q2 <= '0;
    end
    else
    begin
      cause_q1 <= reset_cause;
      cause_q2 <= cause_q1;
    end
  end

  // causes are caught once, after the synchroniser has filled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_cnt <= 2'h0;
    end
    else if (cap_cnt != 2'h3)
    begin
      cap_cnt <= cap_cnt + 2'h1;
    end
  end
  assign capture = (cap_cnt == 2'h2);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cause_flags <= 6'h00;
    end
    else if (capture)
    begin
      // capture wins over a read landing in the same cycle
      if (cause_q2.por)
      begin
        cause_flags <= 6'h00;
        cause_flags[`SRBS_BIT_POR] <= 1'b1;
      end
      else
      begin
        cause_flags[`SRBS_BIT_POR] <= 1'b0;
        cause_flags[`SRBS_BIT_PIN] <= cause_q2.pin;
        cause_flags[`SRBS_BIT_WATCHDOG] <= cause_q2.watchdog;
        cause_flags[`SRBS_BIT_BAD_OPCODE] <= cause_q2.bad_opcode;
        // data accesses to bad addresses do not count
        cause_flags[`SRBS_BIT_BAD_FETCH] <=
          cause_q2.bad_address & cause_q2.address_was_fetch;
        cause_flags[`SRBS_BIT_LOW_VOLTAGE] <=
          cause_q2.low_voltage;
      end
    end
    else if (rd && hit_rc)
    begin
      cause_flags <= 6'h00;
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clear_enable <= 1'b0;
      short_recovery <= 1'b0;
      evt_enable <= `SRBS_RST_EVT;
    end
    else if (wr)
    begin
      if (hit_bc)
      begin
        clear_enable <= pwdata[`SRBS_BIT_CLEAR_ENABLE];
      end
      if (hit_lp)
      begin
        short_recovery <= pwdata[`SRBS_BIT_SHORT_RECOVERY];
      end
      if (hit_ee)
      begin
        evt_enable <= pwdata[1:0];
      end
    end
  end

  // crystal clock is sampled, not used as a clock; it must be well
  // below half of pclk for its edges to be seen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xclk_q1 <= 1'b0;
      xclk_q2 <= 1'b0;
      xclk_q3 <= 1'b0;
    end
    else
    begin
      xclk_q1 <= crystal_clock;
      xclk_q2 <= xclk_q1;
      xclk_q3 <= xclk_q2;
    end
  end
  assign xclk_rise = xclk_q2 & ~xclk_q3;

  assign wake = wake_interrupt | break_irq;
  assign rec_last = short_recovery ? SHORT_LAST : NORMAL_LAST;
  assign rec_end = (lp_state == LP_RECOVER) && xclk_rise
    && (rec_cnt == rec_last);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lp_state <= LP_RUN;
    end
    else
    begin
      unique case (lp_state)
        LP_RUN:
        begin
          if (stop_entry)
          begin
            lp_state <= LP_STOP;
          end
          else if (wait_entry)
          begin
            lp_state <= LP_WAIT;
          end
        end
        LP_WAIT:
        begin
          if (wake)
          begin
            lp_state <= LP_RUN;
          end
        end
        LP_STOP:
        begin
          if (wake)
          begin
            lp_state <= LP_RECOVER;
          end
        end
        LP_RECOVER:
        begin
          if (rec_end)
          begin
            lp_state <= LP_RUN;
          end
        end
      endcase
    end
  end

  // counter runs only in recovery, so it starts from zero each time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rec_cnt <= '0;
    end
    else if (lp_state != LP_RECOVER)
    begin
      rec_cnt <= '0;
    end
    else if (xclk_rise)
    begin
      rec_cnt <= rec_cnt + `SRBS_CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      recovery_done <= 1'b0;
    end
    else
    begin
      recovery_done <= rec_end;
    end
  end
  assign stop_mode = (lp_state == LP_STOP);
  assign recovery_busy = (lp_state == LP_RECOVER);

  // break exit flag; a new break beats a clearing write
  assign set_exit = break_irq && ((lp_state == LP_STOP)
    || (lp_state == LP_WAIT));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exit_flag <= 1'b0;
    end
    else if (set_exit)
    begin
      exit_flag <= 1'b1;
    end
    else if (wr && hit_bs && !pwdata[`SRBS_BIT_EXIT_FLAG])
    begin
      exit_flag <= 1'b0;
    end
  end

  // sticky events, enable gated onto one level interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_status <= `SRBS_RST_EVT;
    end
    else
    begin
      evt_status <= (evt_status & ~((wr && hit_ec) ? pwdata[1:0] : 2'h0))
        | {rec_end, set_exit};
    end
  end
  assign irq = |(evt_status & evt_enable);

  // flag clear gate; no memory, so nothing is restored after break
  // and a second step landing in break is masked like any other
  assign clear_allow = ~break_state | clear_enable;
  generate
    for (genvar g = 0; g < NUM_FLAGS; g++)
    begin : g_gate
      assign flag_clear_grant[g] = flag_clear_request[g]
        & clear_allow;
    end
  endgenerate

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_stop_break;
    (lp_state == LP_STOP) && break_irq |=> exit_flag;
  endproperty
  a_stop_break: assert property (p_stop_break)
    else $error("break in stop did not set exit flag");

  property p_wait_break;
    (lp_state == LP_WAIT) && break_irq |=> exit_flag && lp_state == LP_RUN;
  endproperty
  a_wait_break: assert property (p_wait_break)
    else $error("break in wait did not set exit flag");

  property p_held;
    (lp_state == LP_STOP) |-> rec_cnt == '0;
  endproperty
  a_held: assert property (p_held)
    else $error("recovery counter not held in stop");

  property p_recover_len;
    (lp_state == LP_RECOVER) |-> rec_cnt <= rec_last;
  endproperty
  a_recover_len: assert property (p_recover_len)
    else $error("recovery counter passed its limit");

  property p_recover_end;
    rec_end |=> recovery_done && lp_state == LP_RUN;
  endproperty
  a_recover_end: assert property (p_recover_end)
    else $error("recovery did not end at its count");

  property p_unmapped;
    setup && !mapped |=> pslverr && access;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not flagged");

  property p_exit_clear;
    wr && hit_bs && !pwdata[0] && !set_exit |=> !exit_flag;
  endproperty
  a_exit_clear: assert property (p_exit_clear)
    else $error("writing zero did not clear exit flag");

  property p_read_clear;
    rd && hit_rc && !capture |=> cause_flags == 6'h00;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("reset cause read did not clear flags");

  property p_por_only;
    capture && cause_q2.por |=> cause_flags == 6'h01;
  endproperty
  a_por_only: assert property (p_por_only)
    else $error("power-on did not leave only its bit");

  property p_gate;
    break_state && !clear_enable |-> flag_clear_grant == '0;
  endproperty
  a_gate: assert property (p_gate)
    else $error("flag clear passed during protected break");

  property p_irq;
    $rose(evt_status.break_exit) && evt_enable.break_exit |-> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled event did not raise interrupt");

endmodule
`default_nettype wire

/* File: verif/srbs_tb.sv */
// self-checking bench for the reset and break status block
`timescale 1ns/1ps
`default_nettype none
`include "srbs_regs.svh"
module testbench;
  import srbs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`SRBS_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic stop_entry = 1'b0;
  logic wait_entry = 1'b0;
  logic wake_interrupt = 1'b0;
  logic break_irq = 1'b0;
  logic break_state = 1'b0;
  logic crystal_clock = 1'b0;
  srbs_cause_s reset_cause = '0;
  logic [7:0] flag_clear_request = '0;
  logic [7:0] flag_clear_grant;
  logic stop_mode, recovery_busy, recovery_done, irq;
  logic [31:0] rdata;
  logic rerr;
  int fail_count = 0;
  int compares = 0;
  int seed;
  // por first: it must win over a pin cause held at the same time
  srbs_cause_s causes [7] = '{7'h60, 7'h20, 7'h10, 7'h08, 7'h06, 7'h04,
    7'h01};
  logic [31:0] cexp [7] = '{1, 2, 4, 8, 32'h10, 0, 32'h20};

  // short counts keep recovery runs brief
  srbs_top #(.NORMAL_RECOVERY(8), .SHORT_RECOVERY(4)) srbs_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stop_entry(stop_entry),
    .wait_entry(wait_entry), .wake_interrupt(wake_interrupt),
    .break_irq(break_irq), .break_state(break_state),
    .crystal_clock(crystal_clock), .reset_cause(reset_cause),
    .flag_clear_request(flag_clear_request),
    .flag_clear_grant(flag_clear_grant), .stop_mode(stop_mode),
    .recovery_busy(recovery_busy), .recovery_done(recovery_done),
    .irq(irq)
  );

  always #5 pclk = ~pclk;

  // crystal slower than pclk/2, as the synchroniser needs
  always
  begin
    repeat (3) @(posedge pclk);
    crystal_clock <= ~crystal_clock;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdata, exp);
  endtask

  task do_reset(input srbs_cause_s c);
    presetn <= 1'b0;
    reset_cause <= c;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask

  task pulse_stop();
    @(posedge pclk) stop_entry <= 1'b1;
    @(posedge pclk) stop_entry <= 1'b0;
  endtask

  // wake from stop and count crystal rises seen while recovering
  task recover(input logic brk, input int n);
    int xr;
    logic pc;
    pulse_stop();
    repeat (20) @(posedge pclk);
    chk(32'(stop_mode), 1);
    chk(32'(recovery_busy), 0);
    @(posedge pclk) {break_irq, wake_interrupt} <= {brk, ~brk};
    @(posedge pclk) {break_irq, wake_interrupt} <= 2'b00;
    xr = 0;
    pc = crystal_clock;
    for (int i = 0; i < 2000 && recovery_done !== 1'b1; i++)
    begin
      @(posedge pclk);
      if (crystal_clock && !pc && recovery_busy)
        xr++;
      pc = crystal_clock;
    end
    // synchroniser lag allows one edge of slack either way
    chk(32'(xr >= n - 1 && xr <= n + 1), 1);
    @(posedge pclk);
    #1;
    chk({recovery_done, stop_mode}, 0);
  endtask

  function logic [7:0] exp_grant(logic [7:0] r, logic b, logic e);
    return r & {8{~b | e}};
  endfunction

  task final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #400000;
    fail_count++;
    final_report();
  end

  initial
  begin
    seed = 32'h0694;
    for (int i = 0; i < 7; i++)
    begin
      do_reset(causes[i]);
      rd(`SRBS_IDX_RESET_CAUSE, cexp[i]);
    end
    rd(`SRBS_IDX_RESET_CAUSE, 0);
    apb(1'b0, 16'hFE02, 32'h0);
    chk({rdata, 31'h0, rerr}, 1);
    apb(1'b1, `SRBS_IDX_BREAK_CTRL, 32'hFFFF_FFFF);
    rd(`SRBS_IDX_BREAK_CTRL, 1);
    for (int j = 1; j >= 0; j--)
    begin
      apb(1'b1, `SRBS_IDX_BREAK_CTRL, 32'(j));
      repeat (30)
      begin
        @(posedge pclk);
        flag_clear_request <= 8'($random(seed));
        break_state <= 1'($random(seed));
        @(posedge pclk);
        #1;
        chk(flag_clear_grant, exp_grant(flag_clear_request, break_state,
          1'(j)));
      end
    end
    break_state <= 1'b0;
    apb(1'b1, `SRBS_IDX_EVT_ENABLE, 32'h1);
    recover(1'b1, 8);
    rd(`SRBS_IDX_BREAK_STATUS, 1);
    chk(32'(irq), 1);
    rd(`SRBS_IDX_EVT_STATUS, 3);
    apb(1'b1, `SRBS_IDX_EVT_CLEAR, 32'h3);
    rd(`SRBS_IDX_EVT_STATUS, 0);
    chk(32'(irq), 0);
    apb(1'b1, `SRBS_IDX_BREAK_STATUS, 32'hFFFF_FFFF);
    rd(`SRBS_IDX_BREAK_STATUS, 1);
    apb(1'b1, `SRBS_IDX_BREAK_STATUS, 32'h0);
    rd(`SRBS_IDX_BREAK_STATUS, 0);
    apb(1'b1, `SRBS_IDX_LP_CONFIG, 32'h1);
    recover(1'b0, 4);
    rd(`SRBS_IDX_BREAK_STATUS, 0);
    @(posedge pclk) wait_entry <= 1'b1;
    @(posedge pclk) {wait_entry, break_irq} <= 2'b01;
    @(posedge pclk) break_irq <= 1'b0;
    rd(`SRBS_IDX_BREAK_STATUS, 1);
    do_reset('0);
    rd(`SRBS_IDX_BREAK_STATUS, 0);
    final_report();
  end
endmodule
`default_nettype wire
